// [logic/adcc_buf_if.sv]
/*
 * Handshake bundle between the control core and the result buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface adcc_buf_if;
    logic                         in_valid;
    logic                         in_ready;
    logic [adcc_pkg::RES_W-1:0]   in_data;
    logic                         out_valid;
    logic                         out_ready;
    logic [adcc_pkg::RES_W-1:0]   out_data;
    modport buf_side
    (
        input  in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport core_side
    (
        output in_valid, in_data, out_ready,
        input  in_ready, out_valid, out_data
    );
endinterface

// [logic/adcc_pkg.sv]
/*
 * Constants for the converter's parallel port control block.
 * Assumes a single 10 MHz clock and synchronous pin inputs.
 */
// Contract
// - Deep sleep wake needs 10ms before converting
// - Power down low means shutdown, high runs
// - Depth select high light standby, low sleep
// - Trigger low starts conversion only when selected
// - Triggers ignored while a conversion runs
// - Busy low throughout conversion, high after
// - Falling trigger edge starts the conversion
// - Both strobes tied low: outputs always driven
// - Accept short low pulse or short high gap
// - Read strobe used: outputs float unless read
// - Slow memory: old result shown during conversion
// - New result placed before busy rises; the code updates it on the same clock edge as busy rises
// - ROM: each strobe converts, returns prior result
// - Conversion finishes within 0.75us worst case
// - Light standby wake within 200ns; the code takes three clock edges from power down high, up to 300ns
// - Result is straight binary, twelve bits
package adcc_pkg;
    localparam int RES_W        = 12;
    localparam int CLK_NS       = 100;
    localparam int CONV_MAX_NS  = 750;
    localparam int NAP_WAKE_NS  = 200;
    localparam int SLEEP_WAKE_MS = 10;
    // Longest times round down, at least one cycle
    localparam int CONV_CYC     = (CONV_MAX_NS / CLK_NS) < 1 ? 1
                                  : (CONV_MAX_NS / CLK_NS);
    localparam int NAP_CYC      = (NAP_WAKE_NS / CLK_NS) < 1 ? 1
                                  : (NAP_WAKE_NS / CLK_NS);
    localparam int SLEEP_CYC    = SLEEP_WAKE_MS * 1000000 / CLK_NS;
    localparam int CNT_W        = 17;
    localparam logic [RES_W-1:0] RES_RST = 12'h000;
    typedef enum logic [2:0] {
        ADCC_IDLE, ADCC_CONV, ADCC_NAP, ADCC_SLEEP, ADCC_WAKE
    } adcc_state_t;
endpackage

// [logic/adcc_port_ctrl.sv]
/*
 * Conversion and parallel result port control of a 12-bit converter.
 * Assumes pins synchronous to CLK; sample source is a core input.
 */
`timescale 1ns/10ps
module adcc_port_ctrl
(
    input  wire logic                         CLK,
    input  wire logic                         RST_N,
    input  wire logic                         CONVERSION_TRIGGER_N,
    input  wire logic                         CHIP_SELECT_N,
    input  wire logic                         READ_STROBE_N,
    input  wire logic                         POWER_DOWN_N,
    input  wire logic                         SHUTDOWN_DEPTH_SELECT,
    input  wire logic [adcc_pkg::RES_W-1:0]   SAMPLE_CODE,
    output logic                              BUSY_N,
    output logic [adcc_pkg::RES_W-1:0]        DATA_OUT,
    output logic                              DATA_OE,
    output logic                              RESULT_VALID,
    input  wire logic                         RESULT_READY,
    output logic [adcc_pkg::RES_W-1:0]        RESULT_DATA,
    output logic                              FULL_ACCURACY
);
    adcc_pkg::adcc_state_t      state_r;
    logic [adcc_pkg::CNT_W-1:0] cnt_r;
    logic                       trig_d_r;
    logic                       deep_r;
    logic [adcc_pkg::RES_W-1:0] result_r;
    logic                       start;
    logic                       done;
    adcc_buf_if                 bif ();

    // ****************************************
    // Trigger detect
    // ****************************************
    // Falling edge only, gated by chip select; short pulse or gap
    // Refused while the buffer is full, so a finished word always fits
    // and busy never overruns its bound
    assign start = trig_d_r && !CONVERSION_TRIGGER_N
                   && !CHIP_SELECT_N
                   && bif.in_ready;
    assign done  = (state_r == adcc_pkg::ADCC_CONV)
                   && (cnt_r == adcc_pkg::CNT_W'(adcc_pkg::CONV_CYC - 1));

    // Previous trigger level
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            trig_d_r <= 1'b1;
        else
            trig_d_r <= CONVERSION_TRIGGER_N;
    end

    // ****************************************
    // Conversion and power state machine
    // ****************************************
    // Mode changes and conversion timing
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_r <= adcc_pkg::ADCC_IDLE;
            cnt_r   <= '0;
            deep_r  <= 1'b0;
        end
        else if (!POWER_DOWN_N && state_r != adcc_pkg::ADCC_CONV)
        begin
            // Depth follows the select on every cycle while power down is low and no conversion runs
            if (SHUTDOWN_DEPTH_SELECT)
                state_r <= adcc_pkg::ADCC_NAP;
            else
                state_r <= adcc_pkg::ADCC_SLEEP;
            deep_r <= !SHUTDOWN_DEPTH_SELECT;
            cnt_r  <= '0;
        end
        else
        begin
            case (state_r)
                adcc_pkg::ADCC_IDLE:
                begin
                    cnt_r <= '0;
                    if (start)
                        state_r <= adcc_pkg::ADCC_CONV;
                end
                adcc_pkg::ADCC_CONV:
                begin
                    // Triggers here have no effect
                    if (done)
                    begin
                        state_r <= adcc_pkg::ADCC_IDLE;
                        cnt_r   <= '0;
                    end
                    else if (cnt_r !=
                        adcc_pkg::CNT_W'(adcc_pkg::CONV_CYC - 1))
                        cnt_r <= cnt_r + 1'b1;
                end
                adcc_pkg::ADCC_NAP, adcc_pkg::ADCC_SLEEP:
                begin
                    state_r <= adcc_pkg::ADCC_WAKE;
                    cnt_r   <= '0;
                end
                adcc_pkg::ADCC_WAKE:
                begin
                    // Awake after the depth's recovery time
                    if ((!deep_r && cnt_r ==
                         adcc_pkg::CNT_W'(adcc_pkg::NAP_CYC - 1))
                        || (deep_r && cnt_r ==
                         adcc_pkg::CNT_W'(adcc_pkg::SLEEP_CYC - 1)))
                    begin
                        state_r <= adcc_pkg::ADCC_IDLE;
                        deep_r  <= 1'b0;
                        cnt_r   <= '0;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                end
                default:
                    state_r <= adcc_pkg::ADCC_IDLE;
            endcase
        end
    end

    // ****************************************
    // Result latch and port drive
    // ****************************************
    // Straight binary result captured at the end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            result_r <= adcc_pkg::RES_RST;
        else if (done)
            result_r <= SAMPLE_CODE;
    end

    // Busy low only while converting, high while asleep
    assign BUSY_N = (state_r != adcc_pkg::ADCC_CONV);
    // Old result held until done, new one with busy rise
    assign DATA_OUT = result_r;
    // Drive only while selected and read strobe low
    assign DATA_OE  = !CHIP_SELECT_N && !READ_STROBE_N;
    assign FULL_ACCURACY = (state_r == adcc_pkg::ADCC_IDLE)
                           || (state_r == adcc_pkg::ADCC_CONV);

    // Stream side of the result path
    assign bif.in_valid  = done;
    assign bif.in_data   = SAMPLE_CODE;
    assign bif.out_ready = RESULT_READY;
    assign RESULT_VALID  = bif.out_valid;
    assign RESULT_DATA   = bif.out_data;

    adcc_skid_buf u_buf
    (
        .CLK   (CLK),
        .RST_N (RST_N),
        .bif   (bif)
    );

    // ****************************************
    // Assertions
    // ****************************************
    // Seven cycles of 100ns stay inside the 750ns bound
    property p_busy_bound;
        @(posedge CLK) disable iff (!RST_N)
        $fell(BUSY_N) |-> !BUSY_N [*7] ##1 BUSY_N;
    endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("busy low too long");

    property p_start;
        @(posedge CLK) disable iff (!RST_N)
        (start && state_r == adcc_pkg::ADCC_IDLE && POWER_DOWN_N)
        |=> !BUSY_N;
    endproperty
    a_start: assert property (p_start)
        else $error("trigger did not start conversion");

    property p_no_cs;
        @(posedge CLK) disable iff (!RST_N)
        (CHIP_SELECT_N && BUSY_N && state_r == adcc_pkg::ADCC_IDLE)
        |=> BUSY_N;
    endproperty
    a_no_cs: assert property (p_no_cs)
        else $error("conversion without chip select");

    property p_power_down_n;
        @(posedge CLK) disable iff (!RST_N)
        (!POWER_DOWN_N && BUSY_N) |=> BUSY_N;
    endproperty
    a_power_down_n: assert property (p_power_down_n)
        else $error("conversion in shutdown");

    property p_data_new;
        @(posedge CLK) disable iff (!RST_N)
        done |=> (DATA_OUT == $past(SAMPLE_CODE)) && BUSY_N;
    endproperty
    a_data_new: assert property (p_data_new)
        else $error("result not ready at busy rise");

    property p_data_hold;
        @(posedge CLK) disable iff (!RST_N)
        (!BUSY_N && !done) |=> $stable(DATA_OUT);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("result changed mid conversion");

    property p_oe;
        @(posedge CLK) disable iff (!RST_N)
        DATA_OE == (!CHIP_SELECT_N && !READ_STROBE_N);
    endproperty
    a_oe: assert property (p_oe)
        else $error("output enable wrong");

    property p_nap_wake;
        @(posedge CLK) disable iff (!RST_N)
        (state_r == adcc_pkg::ADCC_NAP && POWER_DOWN_N)
        |=> ##[1:2] state_r == adcc_pkg::ADCC_IDLE;
    endproperty
    a_nap_wake: assert property (p_nap_wake)
        else $error("standby wake too slow");

    c_conv: cover property (@(posedge CLK) $rose(BUSY_N));
    c_nap:  cover property (@(posedge CLK) state_r == adcc_pkg::ADCC_NAP);
    c_full: cover property (@(posedge CLK) !bif.in_ready);
endmodule

// [logic/adcc_skid_buf.sv]
/*
 * Two-entry result buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module adcc_skid_buf
(
    input wire logic CLK,
    input wire logic RST_N,
    adcc_buf_if.buf_side bif
);
    logic [adcc_pkg::RES_W-1:0] mem_r [2];
    logic                       wp_r;
    logic                       rp_r;
    logic [1:0]                 cnt_r;
    logic                       push;
    logic                       pop;

    // Handshake terms
    assign bif.in_ready  = (cnt_r != 2'h2);
    assign bif.out_valid = (cnt_r != 2'h0);
    assign bif.out_data  = mem_r[rp_r];
    assign push = bif.in_valid && bif.in_ready;
    assign pop  = bif.out_valid && bif.out_ready;

    // Storage write
    always_ff @(posedge CLK)
    begin
        if (push)
            mem_r[wp_r] <= bif.in_data;
    end

    // Pointers and fill level
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end
        else
        begin
            if (push)
                wp_r <= ~wp_r;
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// [verif/adcc_host_model.sv]
/*
 * Host model driving the converter port strobes in each port mode.
 * Assumes the bench calls its tasks just after a rising edge of clk.
 */
`timescale 1ns/10ps
module adcc_host_model
(
    input  wire logic                       clk,
    input  wire logic                       busy_n,
    input  wire logic [adcc_pkg::RES_W-1:0] data_out,
    input  wire logic                       data_oe,
    output logic                            conv_n,
    output logic                            cs_n,
    output logic                            rd_n
);
    // ****************************************
    // Strobe sequences
    // ****************************************
    logic [adcc_pkg::RES_W-1:0] seen_old;
    logic [adcc_pkg::RES_W-1:0] seen_new;
    logic                       oe_busy;
    logic                       oe_rd;
    int                         low_cyc;

    // Strobes idle at time zero
    initial
    begin
        conv_n = 1'h1;
        cs_n   = 1'h1;
        rd_n   = 1'h1;
    end

    // Short trigger pulse whose result is not awaited
    task automatic pulse();
        conv_n = 1'h1;
        @(posedge clk) #1;
        conv_n = 1'h0;
        @(posedge clk) #1;
        conv_n = 1'h1;
    endtask

    // Modes: 0 open, 1 high gap, 2 read gated, 3 slow memory, 4 ROM
    task automatic convert(input int mode);
        cs_n = 1'h0;
        rd_n = (mode == 2);
        if (mode == 1 || conv_n === 1'h0)
        begin
            conv_n = 1'h1; // High gap first
            @(posedge clk) #1;
        end
        conv_n = 1'h0;
        @(posedge clk) #1;
        seen_old = data_out;
        oe_busy  = data_oe;
        if (mode != 1 && mode != 3)
            conv_n = 1'h1;
        if (mode == 4)
            rd_n = 1'h1;
        low_cyc = 0;
        // Wait state while busy is low
        while (busy_n === 1'h0 && low_cyc < 50)
        begin
            @(posedge clk) #1;
            low_cyc++;
        end
        seen_new = data_out;
        if (mode == 2)
        begin
            rd_n = 1'h0;
            @(posedge clk) #1;
            seen_new = data_out;
            oe_rd    = data_oe;
        end
        rd_n = (mode >= 2);
        if (mode == 3)
            conv_n = 1'h1; // Release after busy rises
        // Released strobes seen for an edge before the next call
        @(posedge clk) #1;
    endtask
endmodule

// [verif/testbench.sv]
/*
 * Self-checking bench for the converter port control block.
 * Assumes the host model drives the strobes, the bench all else.
 */
`timescale 1ns/10ps
module testbench;
    // ****************************************
    // Signals, clock and instances
    // ****************************************
    logic                       clk    = 1'h0;
    logic                       rst_n;
    logic                       pd_n;
    logic                       depth;
    logic                       ready;
    logic [adcc_pkg::RES_W-1:0] sample;
    logic                       conv_n, cs_n, rd_n, busy_n, data_oe;
    logic                       r_valid, full_acc;
    logic [adcc_pkg::RES_W-1:0] data_out, r_data;
    logic [adcc_pkg::RES_W-1:0] got_q[$];
    int                         n_errors   = 0;
    int                         n_compared = 0;

    always #50 clk = ~clk;

    adcc_port_ctrl dut (.CLK(clk), .RST_N(rst_n),
        .CONVERSION_TRIGGER_N(conv_n), .CHIP_SELECT_N(cs_n),
        .READ_STROBE_N(rd_n), .POWER_DOWN_N(pd_n),
        .SHUTDOWN_DEPTH_SELECT(depth), .SAMPLE_CODE(sample),
        .BUSY_N(busy_n), .DATA_OUT(data_out), .DATA_OE(data_oe),
        .RESULT_VALID(r_valid), .RESULT_READY(ready),
        .RESULT_DATA(r_data), .FULL_ACCURACY(full_acc));
    adcc_host_model host (.clk(clk), .busy_n(busy_n), .data_out(data_out),
        .data_oe(data_oe), .conv_n(conv_n), .cs_n(cs_n), .rd_n(rd_n));

    // Collect words leaving the buffer
    always @(posedge clk)
        if (r_valid === 1'h1 && ready === 1'h1)
            got_q.push_back(r_data);

    // ****************************************
    // Compares and scenarios
    // ****************************************
    task automatic check_bit(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic check_word(input string what, input logic [11:0] e,
                              input logic [11:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    // Busy stays high for n cycles
    task automatic quiet(input int n);
        repeat (n)
        begin
            @(posedge clk) #1;
            check_bit("busy idle", 1'h1, busy_n);
        end
    endtask

    // Every port mode in turn, with the result stream
    task automatic t_modes();
        logic [11:0] codes [6];
        logic [11:0] prev;
        int          modes [6];
        codes = '{12'hfff, 12'h000, 12'h5a3, 12'ha5c, 12'h3c7, 12'h123};
        modes = '{0, 1, 2, 3, 4, 4};
        prev = adcc_pkg::RES_RST;
        got_q.delete();
        for (int i = 0; i < 6; i++)
        begin
            sample = codes[i];
            host.convert(modes[i]);
            check_word("busy cycles", 12'(adcc_pkg::CONV_CYC),
                       12'(host.low_cyc));
            check_word("old data", prev, host.seen_old);
            check_word("new data", codes[i], host.seen_new);
            check_bit("oe", modes[i] != 2, host.oe_busy);
            prev = codes[i];
        end
        check_bit("oe on read", 1'h1, host.oe_rd);
        repeat (3) @(posedge clk) #1;
        for (int i = 0; i < 6; i++)
            check_word("stream", codes[i], got_q[i]);
    endtask

    // Level low, deselected and mid-conversion triggers
    task automatic t_refuse();
        host.convert(1);
        quiet(10);
        host.cs_n = 1'h1;
        host.pulse();
        quiet(10);
        fork
            host.convert(0);
            begin
                repeat (3) @(posedge clk);
                #1 host.pulse();
            end
        join
        check_word("busy cycles", 12'(adcc_pkg::CONV_CYC),
                   12'(host.low_cyc));
        quiet(10);
    endtask

    // Fill the buffer, refuse a trigger while full, then drain
    task automatic t_stall();
        got_q.delete();
        ready = 1'h0;
        sample = 12'h111;
        host.convert(0);
        sample = 12'h222;
        host.convert(0);
        sample = 12'h333;
        host.convert(0);
        check_word("full refuse", 12'h000, 12'(host.low_cyc));
        check_word("held data", 12'h222, host.seen_new);
        ready = 1'h1;
        repeat (3) @(posedge clk) #1;
        check_bit("drained", 1'h0, r_valid);
        host.convert(0);
        check_word("busy cycles", 12'(adcc_pkg::CONV_CYC),
                   12'(host.low_cyc));
        repeat (2) @(posedge clk) #1;
        check_word("count", 12'h003, 12'(got_q.size()));
        check_word("stream", 12'h111, got_q[0]);
        check_word("stream", 12'h222, got_q[1]);
        check_word("stream", 12'h333, got_q[2]);
    endtask

    // Light standby, then deep sleep left by reset
    task automatic t_shutdown();
        int n;
        pd_n = 1'h0;
        repeat (3) @(posedge clk);
        #1 check_bit("nap", 1'h0, full_acc);
        host.pulse();
        quiet(5);
        pd_n = 1'h1;
        n = 0;
        while (full_acc !== 1'h1 && n < 20)
        begin
            @(posedge clk) #1;
            n++;
        end
        check_bit("nap wake", 1'h1, n <= adcc_pkg::NAP_CYC + 1);
        sample = 12'h6b4;
        host.convert(0);
        check_word("after nap", 12'h6b4, host.seen_new);
        depth = 1'h0;
        @(posedge clk) #1 pd_n = 1'h0;
        repeat (3) @(posedge clk);
        #1 pd_n = 1'h1;
        repeat (1000) @(posedge clk);
        #1 check_bit("sleep wake", 1'h0, full_acc);
        host.pulse();
        quiet(5);
        rst_n = 1'h0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'h1;
        check_bit("reset accuracy", 1'h1, full_acc);
    endtask

    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        rst_n  = 1'h0;
        pd_n   = 1'h1;
        depth  = 1'h1;
        ready  = 1'h1;
        sample = 12'h000;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'h1;
        check_bit("reset busy", 1'h1, busy_n);
        check_word("reset data", adcc_pkg::RES_RST, data_out);
        check_bit("reset valid", 1'h0, r_valid);
        @(posedge clk) #1;
        t_modes();
        t_refuse();
        t_stall();
        t_shutdown();
        wrap_up();
    end

    // Watchdog against a hang
    initial
    begin
        #(4000 * 100);
        n_errors++;
        wrap_up();
    end
endmodule
